// file: verilog/periodic_timer.sv
// periodic timer: pwm, single pulse and capture modes behind an avalon-mm slave
//
// Operation
// - pwm period is compare P, zero means 1024
// - duty from compare A, full when A>=period
// - pwm keeps running under output control 00/01
// - clear select ignored in pwm mode
// - single pulse when mode 10, output 11
// - run rising starts counter and pulse
// - external pin edge sets run in pulse
// - compare A match or software ends pulse
// - compare A match in pulse raises flag A
// - pulse counter cleared only on run rising
// - compare P and clear select unused pulse
// - capture mode 01, source pin by select
// - output control picks edges, 11 none
// - capture counter runs until run falls
// - capture copies counter to A, flag A
// - compare P match clears counter, flag P
// - compare P zero counts to full range
// - pulses under one clock may vanish
// - latch within 1.5 clocks, flag after; code latches 2-3 clocks after the pin edge
// - clear, level, invert unused in capture
// - pwm mode when mode 10, output 10
// - initial level sets polarity, invert flips
// - counter and comparators are ten bits
`timescale 1ns/1ps
`include "ptimer_defines.svh"
module periodic_timer (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic ext_clock_pin,
	input wire logic capture_in_pin,
	output logic timer_out,
	output logic timer_out_oe_n,
	output logic match_a_flag,
	output logic match_p_flag
);
	// ---------------------------------------------
	// state
	// ---------------------------------------------
	typedef struct packed {
		logic [`CTRL_WIDTH-1:0] ctrl;
		logic [`CNT_W-1:0] compare_a_value;
		logic [`CNT_W-1:0] compare_p_value;
		logic [`CNT_W-1:0] count;
		logic run_prev;
		logic pwm_level;
		logic pulse_level;
		logic cap_pend;
		logic flag_a_pend;
		logic [31:0] rdata;
		logic ack;
		logic out_pin;
	} timer_state_t;
	timer_state_t state_ff;
	timer_state_t nxt_state;

	// ---------------------------------------------
	// pin synchronisers
	// ---------------------------------------------
	// raw pins ride the interface, edge pulses come back synchronised
	pin_sync_if pins();
	assign pins.ext_clock_raw = ext_clock_pin;
	assign pins.capture_in_raw = capture_in_pin;

	pin_sync u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.pins(pins)
	);

	// ---------------------------------------------
	// decoded control fields
	// ---------------------------------------------
	logic [1:0] mode_field;
	logic [1:0] out_ctrl_field;
	logic run_bit;
	logic out_initial_level;
	logic out_invert;
	logic capture_src_sel;
	ptimer_pkg::mode_t mode;
	logic [10:0] period;
	logic match_a;
	logic match_p;
	logic cap_edge;
	logic bus_req;
	logic wr_ctrl;
	logic wr_a;
	logic wr_p;

	assign mode_field = {state_ff.ctrl[`CTRL_MODE_HI], state_ff.ctrl[`CTRL_MODE_LO]};
	assign out_ctrl_field = {state_ff.ctrl[`CTRL_IO_HI], state_ff.ctrl[`CTRL_IO_LO]};
	assign run_bit = state_ff.ctrl[`CTRL_RUN];
	assign out_initial_level = state_ff.ctrl[`CTRL_OUT_LVL];
	assign out_invert = state_ff.ctrl[`CTRL_OUT_INV];
	assign capture_src_sel = state_ff.ctrl[`CTRL_CAP_SRC];

	// ---------------------------------------------
	// mode decode
	// ---------------------------------------------
	// compare-match and timer modes fall into idle here
	always_comb begin
		mode = ptimer_pkg::MODE_IDLE;
		// 00/01 keep the waveform alive, pin forced later
		if (mode_field == 2'h2 && out_ctrl_field != 2'h3) begin
			mode = ptimer_pkg::MODE_PWM;
		end
		if (mode_field == 2'h2 && out_ctrl_field == 2'h3) begin
			mode = ptimer_pkg::MODE_PULSE;
		end
		if (mode_field == 2'h1) begin
			mode = ptimer_pkg::MODE_CAPTURE;
		end
	end

	// ---------------------------------------------
	// comparators
	// ---------------------------------------------
	// match one below period so each cycle lasts exactly period clocks
	// zero compare P gives 1024
	assign period = (state_ff.compare_p_value == 10'h000) ? 11'h400
		: {1'b0, state_ff.compare_p_value};
	assign match_p = run_bit && ({1'b0, state_ff.count} == period - 11'h001);
	assign match_a = run_bit && (state_ff.count == state_ff.compare_a_value);

	// ---------------------------------------------
	// capture edge select
	// ---------------------------------------------
	// one-cycle edge pulses, so a held level never captures twice
	// source pin select
	// narrow pulses may be lost in sync
	always_comb begin
		logic r;
		logic f;
		r = capture_src_sel ? pins.ext_rise : pins.cap_rise;
		f = capture_src_sel ? pins.ext_fall : pins.cap_fall;
		case (out_ctrl_field)
			2'h0: cap_edge = r;
			2'h1: cap_edge = f;
			2'h2: cap_edge = r | f;
			default: cap_edge = 1'b0;
		endcase
	end

	// ---------------------------------------------
	// bus decode
	// ---------------------------------------------
	// one wait cycle per access; ack drops waitrequest
	// writes land at the first edge; a held request makes that harmless
	assign bus_req = (avs_read | avs_write) & ~state_ff.ack;
	assign wr_ctrl = bus_req & avs_write & (avs_address == `OFS_CTRL);
	assign wr_a = bus_req & avs_write & (avs_address == `OFS_COMPARE_A);
	assign wr_p = bus_req & avs_write & (avs_address == `OFS_COMPARE_P);

	// ---------------------------------------------
	// next state
	// ---------------------------------------------
	always_comb begin
		logic [`CTRL_WIDTH-1:0] wc;
		logic run_next;
		logic set_a;
		logic set_p;
		logic pwm_on;
		nxt_state = state_ff;
		wc = state_ff.ctrl;
		set_a = 1'b0;
		set_p = 1'b0;
		run_next = 1'b0;
		pwm_on = 1'b0;
		nxt_state.ack = bus_req;
		// control write; flag bits are write-one-to-clear
		if (wr_ctrl) begin
			if (avs_byteenable[0]) begin
				wc[7:0] = avs_writedata[7:0];
			end
			if (avs_byteenable[1]) begin
				wc[8] = avs_writedata[8];
				if (avs_writedata[`CTRL_FLAG_A]) begin
					wc[`CTRL_FLAG_A] = 1'b0;
				end
				if (avs_writedata[`CTRL_FLAG_P]) begin
					wc[`CTRL_FLAG_P] = 1'b0;
				end
			end
		end
		// ten-bit comparators, high bits in byte 1
		if (wr_a) begin
			if (avs_byteenable[0]) begin
				nxt_state.compare_a_value[7:0] = avs_writedata[7:0];
			end
			if (avs_byteenable[1]) begin
				nxt_state.compare_a_value[9:8] = avs_writedata[9:8];
			end
		end
		if (wr_p) begin
			if (avs_byteenable[0]) begin
				nxt_state.compare_p_value[7:0] = avs_writedata[7:0];
			end
			if (avs_byteenable[1]) begin
				nxt_state.compare_p_value[9:8] = avs_writedata[9:8];
			end
		end
		// external edge sets run in pulse mode
		if (mode == ptimer_pkg::MODE_PULSE && pins.ext_rise) begin
			wc[`CTRL_RUN] = 1'b1;
		end
		if (mode == ptimer_pkg::MODE_PULSE && match_a && state_ff.run_prev) begin
			wc[`CTRL_RUN] = 1'b0;
			set_a = 1'b1;
		end
		run_next = wc[`CTRL_RUN];
		nxt_state.run_prev = run_bit;
		// count while run high, hold otherwise
		if (run_bit && !state_ff.run_prev) begin
			nxt_state.count = 10'h000;
		end else if (run_bit) begin
			case (mode)
				ptimer_pkg::MODE_PWM: begin
					// compare P match and run rising clear in pwm
					nxt_state.count = match_p ? 10'h000 : state_ff.count + 10'h001;
					set_p = match_p;
					set_a = match_a;
				end
				ptimer_pkg::MODE_PULSE: begin
					// compare P ignored, counter free
					// count parks at A so software can read the width
					if (!match_a) begin
						nxt_state.count = state_ff.count + 10'h001;
					end
				end
				ptimer_pkg::MODE_CAPTURE: begin
					// zero P wraps at full count
					nxt_state.count = match_p ? 10'h000 : state_ff.count + 10'h001;
					set_p = match_p;
				end
				default: begin
					nxt_state.count = state_ff.count + 10'h001;
				end
			endcase
		end
		// capture copies counter into compare A
		// latch this cycle, flag one cycle later
		// flag trails the latch by a clock so A is settled first
		nxt_state.flag_a_pend = 1'b0;
		if (mode == ptimer_pkg::MODE_CAPTURE && run_bit && cap_edge) begin
			nxt_state.compare_a_value = state_ff.count;
			nxt_state.flag_a_pend = 1'b1;
		end
		if (state_ff.flag_a_pend) begin
			set_a = 1'b1;
		end
		// set wins over software clear
		if (set_a) begin
			wc[`CTRL_FLAG_A] = 1'b1;
		end
		if (set_p) begin
			wc[`CTRL_FLAG_P] = 1'b1;
		end
		nxt_state.ctrl = wc;
		// full duty when A reaches period
		// waveform runs independent of pin drive
		pwm_on = ({1'b0, state_ff.compare_a_value} >= period)
			|| (nxt_state.count < state_ff.compare_a_value);
		nxt_state.pwm_level = run_next && pwm_on;
		nxt_state.pulse_level = run_next;
		// output pin drive
		// initial level gives polarity, invert flips
		case (mode)
			ptimer_pkg::MODE_PWM: begin
				nxt_state.out_pin = (nxt_state.pwm_level ~^ out_initial_level) ^ out_invert;
			end
			ptimer_pkg::MODE_PULSE: begin
				// relies on out control staying 11
				nxt_state.out_pin = (nxt_state.pulse_level ~^ out_initial_level) ^ out_invert;
			end
			default: begin
				nxt_state.out_pin = out_initial_level ^ out_invert;
			end
		endcase
		// forced levels when out control 00/01, pwm mode field
		if (mode_field == 2'h2 && out_ctrl_field == 2'h0) begin
			nxt_state.out_pin = 1'b0;
		end
		if (mode_field == 2'h2 && out_ctrl_field == 2'h1) begin
			nxt_state.out_pin = 1'b1;
		end
		// read data mux; unmapped reads as zero
		nxt_state.rdata = 32'h0000_0000;
		if (bus_req && avs_read) begin
			case (avs_address)
				`OFS_CTRL: nxt_state.rdata = {21'h000000, state_ff.ctrl};
				`OFS_COMPARE_A: nxt_state.rdata = {22'h000000, state_ff.compare_a_value};
				`OFS_COMPARE_P: nxt_state.rdata = {22'h000000, state_ff.compare_p_value};
				`OFS_COUNT: nxt_state.rdata = {22'h000000, state_ff.count};
				default: nxt_state.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ---------------------------------------------
	// state register
	// ---------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	// outputs; waitrequest combinational, released on ack cycle
	assign avs_waitrequest = (avs_read | avs_write) & ~state_ff.ack;
	assign avs_readdata = state_ff.rdata;
	assign timer_out = state_ff.out_pin;
	// pin driven in pwm and pulse modes, low enable means driving
	assign timer_out_oe_n = (mode_field == 2'h2) ? 1'b0 : 1'b1;
	assign match_a_flag = state_ff.ctrl[`CTRL_FLAG_A];
	assign match_p_flag = state_ff.ctrl[`CTRL_FLAG_P];
endmodule

// file: common/ptimer_defines.svh
// timing counts, register offsets, field positions and reset values
`ifndef PTIMER_DEFINES_SVH
`define PTIMER_DEFINES_SVH
// register word offsets (byte addresses)
`define OFS_CTRL 4'h0
`define OFS_COMPARE_A 4'h4
`define OFS_COMPARE_P 4'h8
`define OFS_COUNT 4'hC
// control register fields
`define CTRL_RUN 0
`define CTRL_OUT_LVL 1
`define CTRL_OUT_INV 2
`define CTRL_CAP_SRC 3
`define CTRL_CLR_SRC 4
`define CTRL_IO_LO 5
`define CTRL_IO_HI 6
`define CTRL_MODE_LO 7
`define CTRL_MODE_HI 8
`define CTRL_FLAG_A 9
`define CTRL_FLAG_P 10
`define CTRL_WIDTH 11
`define CTRL_RESET 11'h000
// timing: capture latch delay and flag delay in ns, timer clock period
`define TCLK_NS 10
`define LATCH_DELAY_NS 15
`define LATCH_CYCLES ((`LATCH_DELAY_NS - 1) / `TCLK_NS)
`define FLAG_DELAY_NS 5
`define FLAG_CYCLES (((`FLAG_DELAY_NS + `TCLK_NS - 1) / `TCLK_NS))
`define CNT_W 10
`define CNT_MAX 10'h3FF
`endif

// file: common/ptimer_pkg.sv
// types shared by the periodic timer files
package ptimer_pkg;
	typedef enum logic [3:0] {
		MODE_IDLE = 4'h1,
		MODE_PWM = 4'h2,
		MODE_PULSE = 4'h4,
		MODE_CAPTURE = 4'h8
	} mode_t;
endpackage

// file: common/pin_sync_if.sv
// interface carrying raw pins in and synchronised edges out
`timescale 1ns/1ps
interface pin_sync_if;
	logic ext_clock_raw;
	logic capture_in_raw;
	logic ext_rise;
	logic ext_fall;
	logic cap_rise;
	logic cap_fall;
	logic cap_level;
	logic ext_level;
	modport sync (input ext_clock_raw, input capture_in_raw, output ext_rise, output ext_fall,
		output cap_rise, output cap_fall, output cap_level, output ext_level);
	modport core (output ext_clock_raw, output capture_in_raw, input ext_rise, input ext_fall,
		input cap_rise, input cap_fall, input cap_level, input ext_level);
endinterface

// file: verilog/pin_sync.sv
// two-stage synchronisers and edge detectors for the trigger and capture pins
`timescale 1ns/1ps
module pin_sync (
	input wire logic clk_sys,
	input wire logic rst,
	pin_sync_if.sync pins
);
	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] sync;
		logic [1:0] prev;
	} sync_state_t;
	sync_state_t state_ff;
	sync_state_t nxt_state;

	// ---------------------------------------------
	// synchroniser chain
	// ---------------------------------------------
	// meta only feeds sync; edges are taken from sync against prev
	always_comb begin
		nxt_state = state_ff;
		nxt_state.meta = {pins.capture_in_raw, pins.ext_clock_raw};
		nxt_state.sync = state_ff.meta;
		nxt_state.prev = state_ff.sync;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// edge pulses, one cycle each
	assign pins.ext_rise = state_ff.sync[0] & ~state_ff.prev[0];
	assign pins.ext_fall = ~state_ff.sync[0] & state_ff.prev[0];
	assign pins.cap_rise = state_ff.sync[1] & ~state_ff.prev[1];
	assign pins.cap_fall = ~state_ff.sync[1] & state_ff.prev[1];
	assign pins.ext_level = state_ff.sync[0];
	assign pins.cap_level = state_ff.sync[1];
endmodule

// file: tb/pin_model.sv
// far-side model of the trigger and capture pins
`timescale 1ns/1ps
module pin_model (
	input wire logic clk_sys,
	input wire logic [1:0] set_lvl,
	output logic ext_clock_pin,
	output logic capture_in_pin
);
	initial begin
		ext_clock_pin = 1'b0;
		capture_in_pin = 1'b0;
	end
	// levels follow the bench late and are held for many clocks
	always @(posedge clk_sys) begin
		ext_clock_pin <= set_lvl[1];
		capture_in_pin <= set_lvl[0];
	end
endmodule

// file: tb/periodic_timer_props.sv
// port assertions for the periodic timer
`timescale 1ns/1ps
module periodic_timer_props (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic ext_clock_pin,
	input wire logic capture_in_pin,
	input wire logic timer_out,
	input wire logic timer_out_oe_n,
	input wire logic match_a_flag,
	input wire logic match_p_flag
);
	// ----------------
	// software mirrors
	// ----------------
	logic [10:0] ctl_ff;
	logic [9:0] a_ff;
	logic [9:0] p_ff;
	logic [10:0] gap_ff;
	logic [7:0] age_ff;
	logic seen_ff;
	logic wr_ok;
	logic pwm_on;
	logic cap_on;
	logic [10:0] per;
	assign wr_ok = avs_write && !avs_waitrequest;
	assign pwm_on = ctl_ff[8:5] == 4'hA && ctl_ff[0];
	assign cap_on = ctl_ff[8:7] == 2'h1 && !ctl_ff[3] && ctl_ff[0];
	assign per = (p_ff == 10'h000) ? 11'h400 : {1'b0, p_ff};
	// hardware-set bits are not mirrored, only what software wrote
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctl_ff <= 11'h000;
			a_ff <= 10'h000;
			p_ff <= 10'h000;
		end else if (wr_ok) begin
			if (avs_address == 4'h0) ctl_ff <= avs_writedata[10:0];
			if (avs_address == 4'h4) a_ff <= avs_writedata[9:0];
			if (avs_address == 4'h8) p_ff <= avs_writedata[9:0];
		end
	end
	// rise spacing and settle age; a write restarts both
	always_ff @(posedge clk_sys) begin
		if (rst || wr_ok) begin
			gap_ff <= 11'h000;
			age_ff <= 8'h00;
			seen_ff <= 1'b0;
		end else begin
			if (age_ff != 8'hFF) age_ff <= age_ff + 8'h01;
			seen_ff <= seen_ff || $rose(timer_out);
			gap_ff <= $rose(timer_out) ? 11'h001 : gap_ff + 11'h001;
		end
	end
	default clocking dclk @(posedge clk_sys); endclocking
	default disable iff (rst);
	chk_pwm_period: assert property (
		pwm_on && seen_ff && $rose(timer_out) |-> gap_ff == per) else $error("pwm period off");
	chk_full_duty: assert property (
		pwm_on && {1'b0, a_ff} >= per && age_ff == 8'hFF |-> $stable(timer_out))
		else $error("full duty toggles");
	chk_oe_mode: assert property (
		wr_ok && avs_address == 4'h0 |=> timer_out_oe_n == (avs_writedata[8:7] != 2'h2))
		else $error("pin enable wrong");
	chk_wait_first: assert property (
		$rose(avs_read || avs_write) |-> avs_waitrequest) else $error("no wait cycle");
	chk_wait_one: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait too long");
	chk_unmapped_read: assert property (
		avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	chk_count_width: assert property (
		avs_read && !avs_waitrequest |-> avs_readdata[31:11] == 21'h0)
		else $error("wide read data");
	chk_reset_state: assert property (
		$fell(rst) |-> !match_a_flag && !match_p_flag && timer_out_oe_n && !timer_out)
		else $error("reset state wrong");
	chk_cap_flag: assert property (
		cap_on && ctl_ff[6:5] == 2'h2 && $changed(capture_in_pin) |-> ##[2:6] match_a_flag)
		else $error("capture flag late");
	chk_cap_none: assert property (
		cap_on && ctl_ff[6:5] == 2'h3 && $changed(capture_in_pin) && !match_a_flag
		|=> !match_a_flag [*6]) else $error("capture with edges off");
	cover property (pwm_on && $rose(timer_out));
	cover property (cap_on && $rose(match_a_flag));
	cover property (ctl_ff[8:5] == 4'hB && $rose(match_a_flag));
endmodule
bind periodic_timer periodic_timer_props props (.*);

// file: tb/tb_top.sv
// self-checking bench for the periodic timer
`timescale 1ns/1ps
module tb_top;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h3;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic ext_clock_pin;
	logic capture_in_pin;
	logic timer_out;
	logic timer_out_oe_n;
	logic match_a_flag;
	logic match_p_flag;
	logic [1:0] set_lvl = 2'h0;
	logic [31:0] rd;
	logic [31:0] c;
	int fails = 0;
	int tests_run = 0;
	int cyc = 0;
	periodic_timer uut (.*);
	pin_model pins (.*);
	always #5 clk_sys = ~clk_sys;
	task automatic close_out;
		$display("compares %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// hang guard, well above the few thousand cycles needed
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			close_out();
		end
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one avalon cycle; an idle edge after release keeps drivers apart
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic hi_cnt(output int hi);
		hi = 0;
		repeat (32) begin
			@(posedge clk_sys);
			hi += int'(timer_out === 1'b1);
		end
	endtask
	task automatic t_regs;
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, (i == 4) ? 4'h1 : 4'(i * 4), 32'h0);
			cmp(rd, 32'h0);
		end
		bus(1'b1, 4'h4, 32'hFFFFFFFF);
		bus(1'b1, 4'hC, 32'h155);
		bus(1'b1, 4'h1, 32'h155);
		bus(1'b0, 4'h4, 32'h0);
		cmp(rd, 32'h3FF);
		bus(1'b0, 4'hC, 32'h0);
		cmp(rd, 32'h0);
	endtask
	// level and invert both set; four periods hold a fixed high count
	task automatic t_pwm;
		int hi;
		bus(1'b1, 4'h8, 32'h8);
		bus(1'b1, 4'h4, 32'h3);
		bus(1'b1, 4'h0, 32'h157);
		idle(20);
		hi_cnt(hi);
		cmp(32'(hi == 20), 32'h1);
		bus(1'b1, 4'h4, 32'h9);
		idle(260);
		hi_cnt(hi);
		cmp(32'(hi == 0), 32'h1);
		bus(1'b1, 4'h0, 32'h117);
		idle(5);
		cmp(32'(timer_out), 32'h0);
		bus(1'b0, 4'hC, 32'h0);
		cmp(32'(rd < 32'h8), 32'h1);
		bus(1'b1, 4'h8, 32'h0);
		bus(1'b1, 4'h0, 32'h157);
		idle(2100);
	endtask
	// compare P below A must not cut the pulse short
	task automatic t_pulse;
		logic o;
		bus(1'b1, 4'h4, 32'h14);
		bus(1'b1, 4'h8, 32'h5);
		bus(1'b1, 4'h0, 32'h770);
		o = timer_out;
		bus(1'b1, 4'h0, 32'h171);
		idle(5);
		cmp(32'(timer_out !== o), 32'h1);
		idle(40);
		bus(1'b0, 4'h0, 32'h0);
		cmp(rd & 32'h3FF, 32'h370);
		bus(1'b0, 4'hC, 32'h0);
		c = rd;
		cmp(rd, 32'h14);
		bus(1'b1, 4'h0, 32'h770);
		set_lvl <= 2'h2;
		idle(40);
		bus(1'b0, 4'h0, 32'h0);
		cmp(rd & 32'h3FF, 32'h370);
		bus(1'b0, 4'hC, 32'h0);
		cmp(rd, c);
		set_lvl <= 2'h0;
		idle(5);
	endtask
	task automatic cap_once(input logic [31:0] ctl, input logic [1:0] lvl);
		bus(1'b1, 4'h0, ctl);
		idle(50);
		bus(1'b0, 4'hC, 32'h0);
		c = rd;
		set_lvl <= lvl;
		idle(10);
		bus(1'b0, 4'h4, 32'h0);
		cmp(32'(rd > c && rd < c + 32'h14), 32'h1);
		bus(1'b0, 4'h0, 32'h0);
		cmp(32'(rd[9]), 32'h1);
		cmp(32'(match_a_flag), 32'h1);
	endtask
	task automatic t_cap;
		bus(1'b1, 4'h8, 32'h0);
		cap_once(32'h6D7, 2'h1);
		// pin used only as capture source
		cap_once(32'h6DF, 2'h3);
		bus(1'b1, 4'h0, 32'h6F7);
		set_lvl <= 2'h0;
		idle(10);
		bus(1'b0, 4'h0, 32'h0);
		cmp(32'(rd[9]), 32'h0);
		bus(1'b1, 4'h8, 32'h32);
		idle(1100);
		bus(1'b0, 4'hC, 32'h0);
		cmp(32'(rd < 32'h32), 32'h1);
		bus(1'b0, 4'h0, 32'h0);
		cmp(32'(rd[10]), 32'h1);
		cmp(32'(match_p_flag), 32'h1);
		bus(1'b1, 4'h8, 32'h0);
		idle(600);
		bus(1'b0, 4'hC, 32'h0);
		cmp(32'(rd > 32'h226), 32'h1);
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		t_regs();
		t_pwm();
		t_pulse();
		t_cap();
		close_out();
	end
endmodule
